// ==== aom_output_port.sv ====
// output data port of the eight-channel converter: parallel, byte and serial modes
// assumes result pairs arrive from the conversion core on clock_in, and the
// host drives chip select, read strobe and serial clock from outside
//
// Contract
// - strap low: bit 7 pin is parallel bit 7
// - parallel pins driven only while select and read low
// - strap high, byte select low: bit 7/8 pins are serial A/B
// - parallel mode drives result bits 13..9
// - 16-bit mode: bits 15,14 copy bit 13
// - strap high: byte select picks serial or byte
// - high-byte-first sets byte read order
// - byte mode: bit 7 is byte MSB
// - reference select high enables internal reference
// - byte mode: two reads per result
// - serial: select fall gives MSB, sclk rise shifts
module aom_output_port
  import aom_pkg::*;
(
  // clocks and reset
  input  wire logic                         clock_in,
  input  wire logic                         rst_in,
  input  wire logic                         clk_en_in,
  input  wire logic                         serial_clock_in,
  // results from the conversion core: {second, first}
  input  wire logic [aom_pkg::PAIR_WIDTH-1:0] result_pair_in,
  input  wire logic                         result_valid_in,
  output logic                              result_ready_out,
  // host pins
  input  wire logic                         chip_select_n_in,
  input  wire logic                         read_n_in,
  input  wire logic                         interface_select_strap_in,
  input  wire logic                         byte_select_in,
  input  wire logic                         high_byte_first_in,
  input  wire logic                         ref_select_in,
  // data pins
  output logic [aom_pkg::BUS_WIDTH-1:0]     data_bus_out,
  output logic [aom_pkg::BUS_WIDTH-1:0]     data_bus_oe_out,
  output logic                              serial_out_a_out,
  output logic                              serial_out_b_out,
  output logic                              serial_oe_out,
  // reference control
  output logic                              internal_ref_enable_out
);
  import aom_pkg::*;

  // pin synchronisers
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_s1;
  logic [PIN_COUNT-1:0] pin_s2;
  logic [PIN_COUNT-1:0] pin_s3;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] next_pin_level;

  // serial clock domain
  logic [LINK_CNT_WIDTH-1:0] link_cnt;
  logic [LINK_CNT_WIDTH-1:0] next_link_cnt;
  logic [LINK_CNT_WIDTH-1:0] link_gray;

  // edge count brought into the main domain
  logic [LINK_CNT_WIDTH-1:0] gray_s1;
  logic [LINK_CNT_WIDTH-1:0] gray_s2;
  logic [LINK_CNT_WIDTH-1:0] edge_cnt;
  logic [LINK_CNT_WIDTH-1:0] frame_base;
  logic [LINK_CNT_WIDTH-1:0] next_frame_base;
  logic [LINK_CNT_WIDTH-1:0] bit_idx;

  // read sequencing
  logic [1:0]            piece;
  logic [1:0]            next_piece;
  logic                  access_prev;
  logic                  select_prev;
  logic                  access_now;
  logic                  select_now;
  logic                  pop;
  logic [PAIR_WIDTH-1:0] head_pair;
  logic                  head_valid;
  logic                  frame_start;
  logic                  frame_end;
  logic                  read_end;
  logic                  last_piece;

  // mode decode
  logic                    par_mode;
  logic                    byte_mode;
  logic                    ser_mode;
  logic [RESULT_WIDTH-1:0] word;
  logic [RESULT_WIDTH-1:0] ser_word_b;
  logic                    high_byte;
  logic [7:0]              byte_val;

  // registered pins
  logic [BUS_WIDTH-1:0] next_bus;
  logic [BUS_WIDTH-1:0] next_bus_oe;
  logic                 next_ser_a;
  logic                 next_ser_b;
  logic                 next_ser_oe;

  aom_pair_buffer #(
    .WIDTH (PAIR_WIDTH)
  ) u_buffer (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .clk_en_in     (clk_en_in),
    .in_data_in    (result_pair_in),
    .in_valid_in   (result_valid_in),
    .in_ready_out  (result_ready_out),
    .out_data_out  (head_pair),
    .out_valid_out (head_valid),
    .out_ready_in  (pop)
  );

  assign pin_raw[PIN_CS_N]       = chip_select_n_in;
  assign pin_raw[PIN_RD_N]       = read_n_in;
  assign pin_raw[PIN_STRAP]      = interface_select_strap_in;
  assign pin_raw[PIN_BYTE_SEL]   = byte_select_in;
  assign pin_raw[PIN_HIGH_FIRST] = high_byte_first_in;
  assign pin_raw[PIN_REF_SEL]    = ref_select_in;

  // a change counts once the second and third stages agree
  always_comb begin
    next_pin_level = pin_level;
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (pin_s2[i] == pin_s3[i]) begin
        next_pin_level[i] = pin_s3[i];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_s1    <= PIN_RESET;
      pin_s2    <= PIN_RESET;
      pin_s3    <= PIN_RESET;
      pin_level <= PIN_RESET;
    end else if (clk_en_in) begin
      pin_s1    <= pin_raw;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= next_pin_level;
    end
  end

  // serial clock domain: free-running edge count, gray coded for the crossing;
  // counting every edge is safe since the host idles sclk outside frames
  always_comb begin
    next_link_cnt = link_cnt + 5'h01;
  end

  // reset taken asynchronously: the serial clock may not run during reset;
  // limitation: release reset only while the serial clock is idle
  always_ff @(posedge serial_clock_in or posedge rst_in) begin
    if (rst_in) begin
      link_cnt  <= CNT_RESET;
      link_gray <= CNT_RESET;
    end else begin
      link_cnt  <= next_link_cnt;
      link_gray <= next_link_cnt ^ (next_link_cnt >> 1);
    end
  end

  // modes follow the live strap levels
  always_comb begin
    par_mode   = !pin_level[PIN_STRAP];
    byte_mode  = pin_level[PIN_STRAP] && pin_level[PIN_BYTE_SEL];
    ser_mode   = pin_level[PIN_STRAP] && !pin_level[PIN_BYTE_SEL];
    select_now = !pin_level[PIN_CS_N];
    access_now = select_now && !pin_level[PIN_RD_N];
    // gray back to binary: bit i is the parity of bits i and above
    for (int i = 0; i < LINK_CNT_WIDTH; i++) begin
      edge_cnt[i] = ^(gray_s2 >> i);
    end
  end

  // one-cycle edges of the synchronised strobes
  always_comb begin
    frame_start = select_now && !select_prev;
    frame_end   = !select_now && select_prev;
    read_end    = access_prev && !access_now;
    last_piece  = (piece == (byte_mode ? LAST_PIECE_BYTE : LAST_PIECE_WORD));
    if (frame_start) begin
      // base is registered only at this edge, so the first bit is index zero
      bit_idx = CNT_RESET;
    end else begin
      bit_idx = edge_cnt - frame_base;
    end
  end

  // sequencing of reads and frames
  always_comb begin
    next_piece      = piece;
    next_frame_base = frame_base;
    pop             = 1'b0;
    if (ser_mode) begin
      next_piece = 2'h0;
      if (frame_start) begin
        next_frame_base = edge_cnt;
      end
      // the pair is done with once the frame closes
      if (frame_end) begin
        pop = head_valid;
      end
    end else if (read_end) begin
      // a read ends when either strobe rises; byte mode needs two per result
      if (last_piece) begin
        next_piece = 2'h0;
        pop        = head_valid;
      end else begin
        next_piece = piece + 2'h1;
      end
    end
  end

  // what each read presents
  always_comb begin
    word       = '0;
    ser_word_b = '0;
    if (head_valid) begin
      ser_word_b = head_pair[PAIR_WIDTH-1:RESULT_WIDTH];
      if (byte_mode ? piece[1] : piece[0]) begin
        word = head_pair[PAIR_WIDTH-1:RESULT_WIDTH];
      end else begin
        word = head_pair[RESULT_WIDTH-1:0];
      end
    end
    high_byte = (piece[0] == 1'b0) ? pin_level[PIN_HIGH_FIRST]
                                   : !pin_level[PIN_HIGH_FIRST];
    if (high_byte) begin
      byte_val = {word[SIGN_BIT], word[SIGN_BIT], word[SIGN_BIT:8]};
    end else begin
      byte_val = word[7:0];
    end
  end

  // pin drive
  always_comb begin
    next_bus    = BUS_RESET;
    next_bus_oe = BUS_RESET;
    next_ser_a  = 1'b0;
    next_ser_b  = 1'b0;
    next_ser_oe = 1'b0;
    if (par_mode) begin
      next_bus = {word[SIGN_BIT], word[SIGN_BIT], word};
      if (access_now) begin
        next_bus_oe = '1;
      end
    end else if (byte_mode) begin
      // upper pins stay undriven: the board grounds them
      next_bus[7:0] = byte_val;
      if (access_now) begin
        next_bus_oe[7:0] = 8'hFF;
      end
    end else if (select_now) begin
      // bits past the fourteenth shift out as zero
      next_ser_oe = 1'b1;
      if (bit_idx < LINK_CNT_WIDTH'(RESULT_WIDTH)) begin
        next_ser_a = word[4'(SIGN_BIT) - bit_idx[3:0]];
        next_ser_b = ser_word_b[4'(SIGN_BIT) - bit_idx[3:0]];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      gray_s1     <= CNT_RESET;
      gray_s2     <= CNT_RESET;
      frame_base  <= CNT_RESET;
      piece       <= 2'h0;
      access_prev <= 1'b0;
      select_prev <= 1'b0;
    end else if (clk_en_in) begin
      gray_s1     <= link_gray;
      gray_s2     <= gray_s1;
      frame_base  <= next_frame_base;
      piece       <= next_piece;
      access_prev <= access_now;
      select_prev <= select_now;
    end
  end

  // pin registers: every output leaves from a flop, so no glitch reaches a pin
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      data_bus_out            <= BUS_RESET;
      data_bus_oe_out         <= BUS_RESET;
      serial_out_a_out        <= 1'b0;
      serial_out_b_out        <= 1'b0;
      serial_oe_out           <= 1'b0;
      internal_ref_enable_out <= 1'b0;
    end else if (clk_en_in) begin
      data_bus_out            <= next_bus;
      data_bus_oe_out         <= next_bus_oe;
      serial_out_a_out        <= next_ser_a;
      serial_out_b_out        <= next_ser_b;
      serial_oe_out           <= next_ser_oe;
      internal_ref_enable_out <= pin_level[PIN_REF_SEL];
    end
  end
endmodule

// ==== aom_pkg.sv ====
// constants shared by the converter output port: widths, pin layout, counts
// assumes nothing beyond a SystemVerilog compiler
package aom_pkg;
  localparam int RESULT_WIDTH   = 14;
  localparam int BUS_WIDTH      = 16;
  localparam int PAIR_WIDTH     = 2 * RESULT_WIDTH;
  localparam int LINK_CNT_WIDTH = 5;
  localparam int PIN_COUNT      = 6;
  // positions of the synchronised pins
  localparam int PIN_CS_N       = 0;
  localparam int PIN_RD_N       = 1;
  localparam int PIN_STRAP      = 2;
  localparam int PIN_BYTE_SEL   = 3;
  localparam int PIN_HIGH_FIRST = 4;
  localparam int PIN_REF_SEL    = 5;
  // result bit positions on the bus
  localparam int SERIAL_A_BIT   = 7;
  localparam int SERIAL_B_BIT   = 8;
  localparam int SIGN_BIT       = 13;
  // index of the last read per buffered pair of results
  localparam logic [1:0] LAST_PIECE_WORD = 2'h1;
  localparam logic [1:0] LAST_PIECE_BYTE = 2'h3;
  // reset values
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 6'h03;
  localparam logic [BUS_WIDTH-1:0] BUS_RESET = 16'h0000;
  localparam logic [LINK_CNT_WIDTH-1:0] CNT_RESET = 5'h00;
endpackage

// ==== aom_pair_buffer.sv ====
// two-entry buffer with valid and ready on both sides
// assumes one clock and a synchronous active-high reset
module aom_pair_buffer #(
  parameter int WIDTH = 28
) (
  // clock and reset
  input  wire logic             clock_in,
  input  wire logic             rst_in,
  input  wire logic             clk_en_in,
  // filling side
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  // draining side
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  logic [WIDTH-1:0] slot [2];
  logic [WIDTH-1:0] next_slot [2];
  logic [1:0]       fill;
  logic [1:0]       next_fill;
  logic             push;
  logic             pop;

  assign in_ready_out  = (fill != 2'h2);
  assign out_valid_out = (fill != 2'h0);
  assign out_data_out  = slot[0];

  always_comb begin
    push         = in_valid_in && in_ready_out;
    pop          = out_ready_in && out_valid_out;
    next_slot[0] = slot[0];
    next_slot[1] = slot[1];
    next_fill    = fill;
    if (pop) begin
      next_slot[0] = slot[1];
    end
    if (push) begin
      if (fill == 2'h0 || (fill == 2'h1 && pop)) begin
        next_slot[0] = in_data_in;
      end else begin
        next_slot[1] = in_data_in;
      end
    end
    if (push && !pop) begin
      next_fill = fill + 2'h1;
    end else if (pop && !push) begin
      next_fill = fill - 2'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      fill    <= 2'h0;
      slot[0] <= '0;
      slot[1] <= '0;
    end else if (clk_en_in) begin
      fill    <= next_fill;
      slot[0] <= next_slot[0];
      slot[1] <= next_slot[1];
    end
  end
endmodule

// ==== aom_output_port_asserts.sv ====
// checker for the converter output port, bound to its top module
// assumes straps are held still while a read or frame is open
module aom_output_port_asserts
  import aom_pkg::*;
(
  // clock and reset
  input wire logic                          clock_in,
  input wire logic                          rst_in,
  // host pins
  input wire logic                          chip_select_n_in,
  input wire logic                          read_n_in,
  input wire logic                          interface_select_strap_in,
  input wire logic                          byte_select_in,
  input wire logic                          ref_select_in,
  // port outputs
  input wire logic [aom_pkg::BUS_WIDTH-1:0] data_bus_out,
  input wire logic [aom_pkg::BUS_WIDTH-1:0] data_bus_oe_out,
  input wire logic                          serial_oe_out,
  input wire logic                          internal_ref_enable_out
);
  logic rd_on;
  logic strap;
  assign rd_on = !chip_select_n_in && !read_n_in;
  assign strap = interface_select_strap_in;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // seven cycles cover the five-edge pin path
  property p_par_drive;
    (rd_on && !strap)[*7] |=> data_bus_oe_out == 16'hFFFF;
  endproperty
  a_par_drive: assert property (p_par_drive) else $error("bus not driven in read");
  property p_release;
    (chip_select_n_in || read_n_in)[*7] |=> data_bus_oe_out == 16'h0000;
  endproperty
  a_release: assert property (p_release) else $error("bus driven outside read");
  property p_sign_copy;
    data_bus_oe_out[15] |-> data_bus_out[15:14] == {2{data_bus_out[13]}};
  endproperty
  a_sign_copy: assert property (p_sign_copy) else $error("sign bits differ");
  property p_byte_lanes;
    (rd_on && strap && byte_select_in)[*7] |=> data_bus_oe_out == 16'h00FF;
  endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes wrong");
  property p_serial_on;
    (!chip_select_n_in && strap && !byte_select_in)[*7]
      |=> serial_oe_out && data_bus_oe_out[8:7] == 2'b00;
  endproperty
  a_serial_on: assert property (p_serial_on) else $error("serial outputs off");
  property p_serial_off;
    chip_select_n_in[*7] |=> !serial_oe_out;
  endproperty
  a_serial_off: assert property (p_serial_off) else $error("serial on while idle");
  property p_upper_free;
    strap[*7] |=> data_bus_oe_out[13:9] == 5'h00;
  endproperty
  a_upper_free: assert property (p_upper_free) else $error("upper pins driven");
  property p_ref_on;
    $rose(ref_select_in) |-> ##[3:6] internal_ref_enable_out;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference not enabled");
  property p_ref_off;
    $fell(ref_select_in) |-> ##[3:6] !internal_ref_enable_out;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("reference not disabled");
  c_word: cover property ((rd_on && !strap)[*7]);
  c_byte: cover property ((rd_on && strap && byte_select_in)[*7]);
  c_serial: cover property ((!chip_select_n_in && strap && !byte_select_in)[*7]);
endmodule

bind aom_output_port aom_output_port_asserts i_asserts (.clock_in(clock_in), .rst_in(rst_in),
  .chip_select_n_in(chip_select_n_in), .read_n_in(read_n_in),
  .interface_select_strap_in(interface_select_strap_in), .byte_select_in(byte_select_in),
  .ref_select_in(ref_select_in), .data_bus_out(data_bus_out),
  .data_bus_oe_out(data_bus_oe_out), .serial_oe_out(serial_oe_out),
  .internal_ref_enable_out(internal_ref_enable_out));

// ==== aom_host_model.sv ====
// host model: drives chip select, read strobe and a framed serial clock
// assumes the port's outputs are registered on the bench clock
module aom_host_model
  import aom_pkg::*;
(
  // bench clock
  input  wire logic                          clock_in,
  // port outputs
  input  wire logic [aom_pkg::BUS_WIDTH-1:0] data_bus_in,
  input  wire logic                          serial_a_in,
  input  wire logic                          serial_b_in,
  // host pins
  output logic                               chip_select_n_out,
  output logic                               read_n_out,
  output logic                               serial_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    chip_select_n_out = 1'b1;
    read_n_out = 1'b1;
    serial_clock_out = 1'b0;
  end
  // upper pins are grounded by the board, so nothing here drives them
  // strobe low and high for hold cycles, never under 60 ns
  task automatic par_read(input int hold, output logic [15:0] word);
    @(negedge clock_in);
    chip_select_n_out = 1'b0;
    read_n_out = 1'b0;
    repeat (hold) @(negedge clock_in);
    word = data_bus_in;
    read_n_out = 1'b1;
    chip_select_n_out = 1'b1;
    repeat (hold) @(negedge clock_in);
  endtask
  // serial clock runs only inside the frame, sampled before each rise
  task automatic ser_read(output logic [13:0] a, output logic [13:0] b);
    int i;
    @(negedge clock_in);
    chip_select_n_out = 1'b0;
    #83;
    for (i = 13; i >= 0; i--) begin
      a[i] = serial_a_in;
      b[i] = serial_b_in;
      serial_clock_out = 1'b1;
      #40;
      serial_clock_out = 1'b0;
      #40;
    end
    chip_select_n_out = 1'b1;
    repeat (10) @(negedge clock_in);
  endtask
endmodule

// ==== adc_output_bus_mode_mux_test.sv ====
// self-checking bench for the converter output port
// assumes the host model and the bound checker are compiled alongside
module adc_output_bus_mode_mux_test;
  timeunit 1ns;
  timeprecision 1ps;
  import aom_pkg::*;
  logic clock_in, ready, sa, sb, soe, ref_en, valid = 0, rst_in = 0;
  logic strap = 0, bsel = 0, hbf = 1, rsel = 0;
  logic [27:0] pair = 0;
  logic [15:0] bus, oe, w;
  logic [13:0] q [4];
  logic [13:0] a, b;
  wire cs_n, rd_n, sclk;
  wire [15:0] bus_pin;
  wire sa_pin, sb_pin;
  integer n_fail = 0, checked = 0, seed = 32'h0E67, i, h;
  aom_output_port i_dut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(1'b1),
    .serial_clock_in(sclk), .result_pair_in(pair), .result_valid_in(valid),
    .result_ready_out(ready), .chip_select_n_in(cs_n), .read_n_in(rd_n),
    .interface_select_strap_in(strap), .byte_select_in(bsel), .high_byte_first_in(hbf),
    .ref_select_in(rsel), .data_bus_out(bus), .data_bus_oe_out(oe), .serial_out_a_out(sa),
    .serial_out_b_out(sb), .serial_oe_out(soe), .internal_ref_enable_out(ref_en));
  // an undriven pin reads back inverted, so sampling outside the drive shows
  assign bus_pin = bus ^ ~oe;
  assign sa_pin  = sa ^ ~soe;
  assign sb_pin  = sb ^ ~soe;
  aom_host_model i_host (.clock_in(clock_in), .data_bus_in(bus_pin), .serial_a_in(sa_pin),
    .serial_b_in(sb_pin), .chip_select_n_out(cs_n), .read_n_out(rd_n),
    .serial_clock_out(sclk));
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // source holds the pair until taken, so a full buffer just stalls here
  task automatic push(input logic [27:0] p);
    @(negedge clock_in);
    pair = p;
    valid = 1'b1;
    while (ready !== 1'b1) @(negedge clock_in);
    @(negedge clock_in);
    valid = 1'b0;
  endtask
  task automatic draw;
    for (int k = 0; k < 4; k++) q[k] = 14'($random(seed));
  endtask
  function automatic logic [15:0] byte_of(input logic [13:0] r, input logic hi);
    return hi ? {8'h00, r[13], r[13], r[13:8]} : {8'h00, r[7:0]};
  endfunction
  initial begin
    #100000;
    n_fail++;
    results;
  end
  initial begin
    // a real rising edge, so the serial side resets while its clock is idle
    @(negedge clock_in);
    rst_in = 1'b1;
    repeat (12) @(negedge clock_in);
    rst_in = 1'b0;
    @(negedge clock_in);
    check("ready", {15'h0, ready}, 16'h0001);
    check("oe", oe, 16'h0000);
    repeat (4) @(negedge clock_in);
    // empty buffer reads as zero; two reads keep the piece order aligned
    for (i = 0; i < 2; i++) begin
      i_host.par_read(8, w);
      check("empty", w, 16'h0000);
    end
    draw;
    q[0] = 14'h2000;
    q[1] = 14'h1FFF;
    push({q[1], q[0]});
    push({q[3], q[2]});
    check("full", {15'h0, ready}, 16'h0000);
    for (i = 0; i < 4; i++) begin
      i_host.par_read(8 + i, w);
      check("word", w, {q[i][13], q[i][13], q[i]});
    end
    strap = 1'b1;
    bsel = 1'b1;
    for (h = 1; h >= 0; h--) begin
      hbf = h[0];
      draw;
      push({q[1], q[0]});
      repeat (8) @(negedge clock_in);
      for (i = 0; i < 4; i++) begin
        i_host.par_read(8, w);
        check("byte", {8'h00, w[7:0]}, byte_of(q[i/2], (i % 2 == 0) == (h == 1)));
      end
    end
    bsel = 1'b0;
    repeat (8) @(negedge clock_in);
    for (h = 0; h < 2; h++) begin
      draw;
      push({q[1], q[0]});
      i_host.ser_read(a, b);
      check("serial a", {2'b00, a}, {2'b00, q[0]});
      check("serial b", {2'b00, b}, {2'b00, q[1]});
      check("serial oe", {15'h0, soe}, 16'h0000);
    end
    for (h = 1; h >= 0; h--) begin
      rsel = h[0];
      repeat (8) @(negedge clock_in);
      check("ref", {15'h0, ref_en}, {15'h0, h[0]});
    end
    results;
  end
endmodule
